// ===== bench/test_vfcw_top.sv
// test_vfcw_top.sv: self-checking bench of the video field capture writer.
// assumes vfcw_top and vfcw_mem_model compiled before it.
`timescale 1ns/100ps
`default_nettype none
`include "vfcw_defs.svh"
module test_vfcw_top;
    logic clk = 1'b0, arst_n = 1'b0, slow = 1'b0;
    logic [4:0] av_address = 5'h00;
    logic av_read = 1'b0, av_write = 1'b0, av_waitrequest, mem_write, mem_waitrequest;
    logic [31:0] av_writedata = 32'h0, av_readdata, mem_address, mem_writedata, rd;
    logic fs = 1'b0, odd = 1'b0, ls = 1'b0, pv = 1'b0, ilv;
    logic [7:0] r = 8'h00, g = 8'h00, b = 8'h00, y = 8'h00, cb = 8'h00, cr = 8'h00;
    logic [2:0] fmt;
    logic [95:0] grp;
    logic [63:0] expq[$];
    logic [31:0] base_e = 32'h0000_1000, base_o = 32'h0000_1100;
    integer seed = 32'h9BF0, n_mismatch = 0, checks = 0;
    int lbt[7] = '{32, 24, 16, 16, 16, 12, 8};
    int gpt[7] = '{1, 4, 2, 2, 2, 8, 4};
    int nwt[7] = '{1, 3, 1, 1, 1, 3, 1};

    // 10 MHz clock
    initial forever #50 clk = ~clk;

    vfcw_top i_vfcw_top (.clk(clk), .arst_n(arst_n), .av_address(av_address), .av_read(av_read),
        .av_write(av_write), .av_writedata(av_writedata), .av_readdata(av_readdata),
        .av_waitrequest(av_waitrequest), .vid_field_start(fs), .vid_odd(odd), .vid_line_start(ls),
        .vid_pix_valid(pv), .vid_r(r), .vid_g(g), .vid_b(b), .vid_y(y), .vid_cb(cb), .vid_cr(cr),
        .mem_address(mem_address), .mem_writedata(mem_writedata), .mem_write(mem_write),
        .mem_waitrequest(mem_waitrequest));
    vfcw_mem_model i_vfcw_mem_model (.clk(clk), .arst_n(arst_n), .mem_write(mem_write), .slow(slow),
        .mem_waitrequest(mem_waitrequest));

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task wrap_up;
        $display("checks=%0d mismatches=%0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    // one register access; request held until waitrequest is sampled low
    task acc(input logic we, input logic [4:0] a, input logic [31:0] d);
        int i;
        @(posedge clk);
        av_address <= a;
        av_writedata <= d;
        av_write <= we;
        av_read <= !we;
        for (i = 0; i < 50; i++) begin
            @(posedge clk);
            if (av_waitrequest === 1'b0) break;
        end
        if (i == 50) begin
            n_mismatch++;
            wrap_up;
        end
        rd = av_readdata;
        av_write <= 1'b0;
        av_read <= 1'b0;
    endtask

    task rdm(input logic [4:0] a, input logic [31:0] m, input logic [31:0] e);
        acc(1'b0, a, 32'h0);
        chk(rd & m, e);
    endtask

    // drop one pixel's bytes into the expected packing group
    task automatic place(input int k, input logic [47:0] p);
        logic [7:0] pr, pg, pb, py, pcb, pcr;
        {pr, pg, pb, py, pcb, pcr} = p;
        case (fmt)
            `VFCW_FMT_RGB32: grp[k*32+:32] = {8'h00, pr, pg, pb};
            `VFCW_FMT_RGB24: grp[k*24+:24] = {pr, pg, pb};
            `VFCW_FMT_RGB16: grp[k*16+:16] = {pr[7:3], pg[7:2], pb[7:3]};
            `VFCW_FMT_RGB15: grp[k*16+:16] = {1'b0, pr[7:3], pg[7:3], pb[7:3]};
            `VFCW_FMT_YUY2: begin
                grp[k*16+:8] = py;
                if (k == 0) grp[31:24] = pcr;
                if (k == 0) grp[15:8] = pcb;
            end
            `VFCW_FMT_P411: begin
                grp[(k < 4 ? 16*k+8 : 8*k+32)+:8] = py;
                if (k == 0 || k == 4) grp[8*k+:8] = pcb;
                if (k == 0 || k == 4) grp[8*k+16+:8] = pcr;
            end
            default: grp[k*8+:8] = py;
        endcase
    endtask

    // one field of two lines of eight pixels; cap notes the expected writes
    task field(input logic par, input logic cap, input logic mid);
        logic [31:0] a;
        logic [47:0] p;
        @(posedge clk) fs <= 1'b1;
        odd <= par;
        @(posedge clk) fs <= 1'b0;
        for (int ln = 0; ln < 2; ln++) begin
            if (mid && ln == 1) acc(1'b1, `VFCW_OFF_CMD, 32'h1);
            @(posedge clk) ls <= 1'b1;
            @(posedge clk) ls <= 1'b0;
            a = ilv ? base_e + (par ? lbt[fmt] : 0) + 2 * ln * lbt[fmt]
                    : (par ? base_o : base_e) + ln * lbt[fmt];
            grp = '0;
            for (int k = 0; k < 8; k++) begin
                p = {$random(seed), $random(seed)};
                place(k % gpt[fmt], p);
                if (k % gpt[fmt] == gpt[fmt] - 1) begin
                    for (int j = 0; j < nwt[fmt]; j++) begin
                        if (cap) expq.push_back({a, grp[32*j+:32]});
                        a += 4;
                    end
                    grp = '0;
                end
                @(posedge clk) {r, g, b, y, cb, cr} <= p;
                pv <= 1'b1;
                @(posedge clk) pv <= 1'b0;
                repeat (5) @(posedge clk);
            end
        end
    endtask

    // every accepted memory word is matched against the oldest note
    always @(posedge clk) begin
        if (mem_write === 1'b1 && mem_waitrequest === 1'b0) begin
            if (expq.size() == 0) chk(32'h1, 32'h0);
            else begin
                chk(mem_address, expq[0][63:32]);
                chk(mem_writedata, expq[0][31:0]);
                void'(expq.pop_front());
            end
        end
    end

    // hang guard
    initial begin
        repeat (90000) @(posedge clk);
        n_mismatch++;
        wrap_up;
    end

    initial begin
        repeat (11) @(posedge clk);
        chk(32'(av_waitrequest), 32'h1);
        chk(32'(mem_write), 32'h0);
        @(posedge clk) arst_n <= 1'b1;
        rdm(`VFCW_OFF_LPIX, 32'hFFF, 32'(`VFCW_LPIX_RST));
        rdm(`VFCW_OFF_FLINES, 32'h3FF, 32'(`VFCW_FLINES_RST));
        rdm(`VFCW_OFF_STATUS, 32'h3, 32'h0);
        rdm(5'h1C, 32'hFFFF_FFFF, 32'h0);
        acc(1'b1, `VFCW_OFF_LPIX, 32'h8);
        acc(1'b1, `VFCW_OFF_FLINES, 32'h2);
        acc(1'b1, `VFCW_OFF_BASE_E, base_e);
        acc(1'b1, `VFCW_OFF_BASE_O, base_o);
        rdm(`VFCW_OFF_BASE_O, 32'hFFFF_FFFF, base_o);
        // one-shot in every format, started inside an even or an odd field
        for (int f = 0; f < 7; f++) begin
            fmt = 3'(f);
            ilv = f[0];
            slow <= f[1];
            acc(1'b1, `VFCW_OFF_CTRL, 32'({1'b1, ilv, fmt}));
            field(1'b0, 1'b0, 1'b0);
            field(ilv, 1'b0, 1'b1);
            if (!ilv) field(1'b1, 1'b0, 1'b0);
            field(1'b0, 1'b1, 1'b0);
            field(1'b1, 1'b1, 1'b0);
            field(1'b0, 1'b0, 1'b0);
            rdm(`VFCW_OFF_STATUS, 32'h3, 32'h3);
            acc(1'b1, `VFCW_OFF_CMD, 32'h1);
            field(1'b0, 1'b0, 1'b0);
            acc(1'b1, `VFCW_OFF_CMD, 32'h2);
            rdm(`VFCW_OFF_STATUS, 32'h3, 32'h0);
        end
        // continuous capture, separate regions then interleaved frame
        slow <= 1'b1;
        fmt = `VFCW_FMT_RGB32;
        for (int m = 0; m < 2; m++) begin
            ilv = m[0];
            acc(1'b1, `VFCW_OFF_CTRL, 32'({1'b0, ilv, fmt}));
            acc(1'b1, `VFCW_OFF_CMD, 32'h1);
            repeat (2) begin
                field(1'b0, 1'b1, 1'b0);
                field(1'b1, 1'b1, 1'b0);
            end
            acc(1'b1, `VFCW_OFF_CMD, 32'h2);
            field(1'b0, 1'b0, 1'b0);
        end
        repeat (20) @(posedge clk);
        chk(32'(expq.size()), 32'h0);
        wrap_up;
    end
endmodule // test_vfcw_top
`default_nettype wire

// ===== bench/vfcw_mem_model.sv
// vfcw_mem_model.sv: host memory bridge seen by the writer's write master.
// assumes the bench clock and reset; slow asks for random stalls.
`timescale 1ns/100ps
`default_nettype none
module vfcw_mem_model (
    // clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // write master side, plus the bench's stall switch
    input wire logic mem_write,
    input wire logic slow,
    output logic mem_waitrequest
);
    integer seed = 32'h9BF0;
    integer rnd;
    integer stl = 0;
    // stalls come also while idle, so the design may not rely on a quiet bridge
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            mem_waitrequest <= 1'b1;
        end else begin
            rnd = $random(seed);
            // a stall run is cut after two cycles, so the pixel spacing always drains a group
            if (stl == 2) rnd[0] = 1'b0;
            mem_waitrequest <= slow & rnd[0] & (rnd[1] | mem_write);
            stl = (slow & rnd[0] & (rnd[1] | mem_write)) ? stl + 1 : 0;
        end
    end
endmodule // vfcw_mem_model
`default_nettype wire

// ===== verilog/vfcw_defs.svh
// vfcw_defs.svh: register offsets, field positions, pixel format codes
// and reset values of the video field capture writer.
// assumes inclusion by bare name from files under verilog/.
`ifndef VFCW_DEFS_SVH
`define VFCW_DEFS_SVH

// register byte offsets on the slave port
`define VFCW_OFF_CTRL 5'h00
`define VFCW_OFF_CMD 5'h04
`define VFCW_OFF_BASE_E 5'h08
`define VFCW_OFF_BASE_O 5'h0C
`define VFCW_OFF_LPIX 5'h10
`define VFCW_OFF_FLINES 5'h14
`define VFCW_OFF_STATUS 5'h18

// bit positions
`define VFCW_CTRL_ILV 3
`define VFCW_CTRL_ONE 4
`define VFCW_CMD_START 0
`define VFCW_CMD_HALT 1
`define VFCW_ST_OVR 2
`define VFCW_ST_BADW 3

// pixel format codes
`define VFCW_FMT_RGB32 3'h0
`define VFCW_FMT_RGB24 3'h1
`define VFCW_FMT_RGB16 3'h2
`define VFCW_FMT_RGB15 3'h3
`define VFCW_FMT_YUY2 3'h4
`define VFCW_FMT_P411 3'h5
`define VFCW_FMT_Y8 3'h6

// reset values
`define VFCW_FMT_RST 3'h0
`define VFCW_LPIX_RST 12'h2D0
`define VFCW_FLINES_RST 10'h120

`endif

// ===== verilog/vfcw_pkg.sv
// vfcw_pkg.sv: types of the video field capture writer.
// assumes nothing beyond a SystemVerilog compiler.
package vfcw_pkg;

    // capture sequencer states
    typedef enum logic [1:0] {ST_IDLE, ST_SYNC, ST_RUN, ST_LOCK} vfcw_state_t;

    // bytes one pixel contributes to its packing group
    typedef struct packed {
        logic [11:0] mask;
        logic [95:0] data;
    } vfcw_place_t;

    // complete state of the writer
    typedef struct packed {
        vfcw_state_t st;
        logic [2:0] fmt;
        logic ilv;
        logic one;
        logic [31:0] base_e;
        logic [31:0] base_o;
        logic [11:0] lpix;
        logic [9:0] flines;
        logic ovr;
        logic [3:0] fcnt;
        logic [1:0] fdone;
        logic cap;
        logic line_on;
        logic [11:0] pcnt;
        logic [9:0] lcnt;
        logic [2:0] gidx;
        logic [95:0] grp;
        logic [31:0] cur_addr;
        logic [31:0] line_base;
        logic [95:0] obuf;
        logic [1:0] ocnt;
        logic [31:0] oaddr;
        logic mwr;
        logic [31:0] maddr;
        logic [31:0] mdata;
        logic wait_hi;
        logic [31:0] rdata;
    } vfcw_regs_t;

endpackage

// ===== verilog/vfcw_top.sv
// vfcw_top.sv: video field capture writer; packs captured pixels and
// writes them to host memory through an Avalon-MM write master.
// assumes the video decoder and the memory bridge run on clk.
`timescale 1ns/100ps
`default_nettype none
`include "vfcw_defs.svh"

// Overview of operation
// R1: grey format stores one 8-bit luminance byte per pixel, back to back.
// R2: one field spans line pixels times field lines times pixel byte size.
// R3: 4:2:2 groups two pixels, 4:1:1 groups eight; line width must fit.
// R4: host sizes a frame buffer as even plus odd field requirements.
// R5: interleave flag set puts both fields' lines alternately in one region.
// R6: one-shot flag clear captures every field continuously after start.
// R7: separate regions continuously alternate, one field each, per region.
// R8: interleaved continuous capture writes even lines then odd lines repeatedly.
// R9: one-shot flag set captures one even and one odd field, then stops.
// R10: configuration writes never start capture; only the start command does.
// R11: capture begins at the next whole field, never mid-field.
// R12: continuous runs until halt; one-shot finishes alone after one image.
// R13: capture sequences are whole frames starting on an even field.
// R14: started during an even field, skip it and the odd, take next even.
// R15: started during an odd field, capture the even field right after.
// R16: host should halt around evaluation or use alternating regions.
// R17: 32-bit colour puts blue, green, red in bytes 0..2, top byte zero.
// R18: 16-bit colour packs red 5, green 6, blue 5 most significant bits.
// R19: 15-bit colour packs three 5-bit channels, top word bit zero.
// R20: after one-shot, stay locked until halt; then start may shoot again.
// R21: packed words go to ascending consecutive addresses from the region base.
module vfcw_top
    import vfcw_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // avalon-mm register slave
    input wire logic [4:0] av_address,
    input wire logic av_read,
    input wire logic av_write,
    input wire logic [31:0] av_writedata,
    output logic [31:0] av_readdata,
    output logic av_waitrequest,
    // decoded video from the decoder, same clock
    input wire logic vid_field_start,
    input wire logic vid_odd,
    input wire logic vid_line_start,
    input wire logic vid_pix_valid,
    input wire logic [7:0] vid_r,
    input wire logic [7:0] vid_g,
    input wire logic [7:0] vid_b,
    input wire logic [7:0] vid_y,
    input wire logic [7:0] vid_cb,
    input wire logic [7:0] vid_cr,
    // avalon-mm write master towards host memory
    output logic [31:0] mem_address,
    output logic [31:0] mem_writedata,
    output logic mem_write,
    input wire logic mem_waitrequest
);

    vfcw_regs_t s_reg;
    vfcw_regs_t s_next;
    logic bus_wr;
    logic start_cmd;
    logic halt_cmd;
    logic pix_take;
    logic bad_width;
    logic [31:0] lb;
    logic [31:0] stride;
    vfcw_place_t pl;

    // bytes occupied by one line of the selected format
    function automatic logic [31:0] line_bytes(input logic [2:0] f, input logic [11:0] n);
        logic [31:0] w;
        w = {20'h0, n};
        case (f)
            `VFCW_FMT_RGB32: line_bytes = w << 2;
            `VFCW_FMT_RGB24: line_bytes = (w << 1) + w;
            `VFCW_FMT_RGB16, `VFCW_FMT_RGB15, `VFCW_FMT_YUY2: line_bytes = w << 1;
            `VFCW_FMT_P411: line_bytes = w + (w >> 1);
            default: line_bytes = w;
        endcase
    endfunction

    // pixels in one packing group
    function automatic logic [3:0] grp_px(input logic [2:0] f);
        case (f)
            `VFCW_FMT_RGB32: grp_px = 4'h1;
            `VFCW_FMT_RGB24, `VFCW_FMT_Y8: grp_px = 4'h4;
            `VFCW_FMT_P411: grp_px = 4'h8;
            default: grp_px = 4'h2;
        endcase
    endfunction

    // words in one packing group
    function automatic logic [1:0] grp_words(input logic [2:0] f);
        if (f == `VFCW_FMT_RGB24 || f == `VFCW_FMT_P411) begin
            grp_words = 2'h3;
        end else begin
            grp_words = 2'h1;
        end
    endfunction

    // where pixel i of a group lands inside the 12-byte group
    function automatic vfcw_place_t place(input logic [2:0] f, input logic [2:0] i,
                                          input logic [7:0] r, input logic [7:0] g,
                                          input logic [7:0] b, input logic [7:0] y,
                                          input logic [7:0] cb, input logic [7:0] cr);
        vfcw_place_t p;
        logic [3:0] pos;
        p = '0;
        pos = (i < 3'h4) ? {1'b0, i[1:0], 1'b1} : {2'h2, i[1:0]};
        case (f)
            `VFCW_FMT_RGB32: begin
                p.data = {64'h0, 8'h00, r, g, b}; // see R17
                p.mask = 12'h00F;
            end
            `VFCW_FMT_RGB24: begin
                p.data = {72'h0, r, g, b} << (24 * i);
                p.mask = 12'h007 << (3 * i);
            end
            `VFCW_FMT_RGB16: begin
                p.data = {80'h0, r[7:3], g[7:2], b[7:3]} << (16 * i[0]); // see R18
                p.mask = 12'h003 << (2 * i[0]);
            end
            `VFCW_FMT_RGB15: begin
                p.data = {80'h0, 1'b0, r[7:3], g[7:3], b[7:3]} << (16 * i[0]); // see R19
                p.mask = 12'h003 << (2 * i[0]);
            end
            `VFCW_FMT_YUY2: begin
                // first pixel carries the shared chroma; see R3
                if (!i[0]) begin
                    p.data = {64'h0, cr, 8'h00, cb, y};
                    p.mask = 12'h00B;
                end else begin
                    p.data = {72'h0, y, 16'h0000};
                    p.mask = 12'h004;
                end
            end
            `VFCW_FMT_P411: begin
                // chroma only from pixels 0 and 4 of the eight; see R3
                p.data = {88'h0, y} << (8 * pos);
                p.mask = 12'h001 << pos;
                if (i == 3'h0) begin
                    p.data[7:0] = cb;
                    p.data[23:16] = cr;
                    p.mask = p.mask | 12'h005;
                end else if (i == 3'h4) begin
                    p.data[39:32] = cb;
                    p.data[55:48] = cr;
                    p.mask = p.mask | 12'h050;
                end
            end
            default: begin
                p.data = {88'h0, y} << (8 * i[1:0]); // one byte per pixel, see R1
                p.mask = 12'h001 << i[1:0];
            end
        endcase
        place = p;
    endfunction

    // slave strobes: a write acts at the edge where waitrequest is low
    assign bus_wr = av_write && !s_reg.wait_hi;
    assign start_cmd = bus_wr && av_address == `VFCW_OFF_CMD && av_writedata[`VFCW_CMD_START]; // see R10
    assign halt_cmd = bus_wr && av_address == `VFCW_OFF_CMD && av_writedata[`VFCW_CMD_HALT];
    assign pix_take = s_reg.line_on && vid_pix_valid && s_reg.pcnt < s_reg.lpix;
    // group sizes are powers of two, so a mask tests the fit
    assign bad_width = (s_reg.lpix[3:0] & (grp_px(s_reg.fmt) - 4'h1)) != 4'h0; // see R3
    assign lb = line_bytes(s_reg.fmt, s_reg.lpix); // see R2
    assign stride = s_reg.ilv ? (lb << 1) : lb; // see R5
    assign pl = place(s_reg.fmt, s_reg.gidx, vid_r, vid_g, vid_b, vid_y, vid_cb, vid_cr);

    // next state of the whole writer
    always_comb begin
        s_next = s_reg;

        // register slave: one wait cycle, then a single-cycle answer
        s_next.wait_hi = 1'b1;
        if ((av_read || av_write) && s_reg.wait_hi) begin
            s_next.wait_hi = 1'b0;
            if (av_address == `VFCW_OFF_CTRL) begin
                s_next.rdata = {27'h0, s_reg.one, s_reg.ilv, s_reg.fmt};
            end else if (av_address == `VFCW_OFF_BASE_E) begin
                s_next.rdata = s_reg.base_e;
            end else if (av_address == `VFCW_OFF_BASE_O) begin
                s_next.rdata = s_reg.base_o;
            end else if (av_address == `VFCW_OFF_LPIX) begin
                s_next.rdata = {20'h0, s_reg.lpix};
            end else if (av_address == `VFCW_OFF_FLINES) begin
                s_next.rdata = {22'h0, s_reg.flines};
            end else if (av_address == `VFCW_OFF_STATUS) begin
                s_next.rdata = {24'h0, s_reg.fcnt, bad_width, s_reg.ovr, s_reg.st};
            end else begin
                s_next.rdata = 32'h0000_0000;
            end
        end

        // register writes only configure; nothing here starts capture
        if (bus_wr) begin
            if (av_address == `VFCW_OFF_CTRL) begin
                s_next.fmt = av_writedata[2:0];
                s_next.ilv = av_writedata[`VFCW_CTRL_ILV];
                s_next.one = av_writedata[`VFCW_CTRL_ONE];
            end else if (av_address == `VFCW_OFF_BASE_E) begin
                s_next.base_e = av_writedata;
            end else if (av_address == `VFCW_OFF_BASE_O) begin
                s_next.base_o = av_writedata;
            end else if (av_address == `VFCW_OFF_LPIX) begin
                s_next.lpix = av_writedata[11:0];
            end else if (av_address == `VFCW_OFF_FLINES) begin
                s_next.flines = av_writedata[9:0];
            end else if (av_address == `VFCW_OFF_STATUS && av_writedata[`VFCW_ST_OVR]) begin
                s_next.ovr = 1'b0; // a new overrun below wins over this clear
            end
        end

        // write master: hold the word until the bridge takes it
        if (!s_reg.mwr || !mem_waitrequest) begin
            s_next.mwr = 1'b0;
            if (s_reg.ocnt != 2'h0) begin
                s_next.mwr = 1'b1;
                s_next.maddr = s_reg.oaddr;
                s_next.mdata = s_reg.obuf[31:0];
                s_next.obuf = s_reg.obuf >> 32;
                s_next.oaddr = s_reg.oaddr + 32'h4; // see R21
                s_next.ocnt = s_reg.ocnt - 2'h1;
            end
        end

        // line start: open the line and step the line base
        if (s_reg.cap && vid_line_start) begin
            s_next.pcnt = 12'h000;
            s_next.gidx = 3'h0;
            s_next.line_on = s_reg.lcnt < s_reg.flines;
            if (s_reg.lcnt < s_reg.flines) begin
                s_next.cur_addr = s_reg.line_base; // see R21
                s_next.line_base = s_reg.line_base + stride; // see R2
                s_next.lcnt = s_reg.lcnt + 10'h001;
            end
        end

        // pixel packing; a partial group at line end is dropped
        if (pix_take) begin
            s_next.grp = ((s_reg.gidx == 3'h0) ? 96'h0 : s_reg.grp) | pl.data;
            s_next.pcnt = s_reg.pcnt + 12'h001;
            s_next.gidx = s_reg.gidx + 3'h1;
            if ({1'b0, s_reg.gidx} == grp_px(s_reg.fmt) - 4'h1) begin
                s_next.gidx = 3'h0;
                // no buffering: a group finished while words still wait is lost
                if (s_next.ocnt != 2'h0) begin
                    s_next.ovr = 1'b1;
                end else begin
                    s_next.obuf = s_next.grp;
                    s_next.ocnt = grp_words(s_reg.fmt);
                    s_next.oaddr = s_reg.cur_addr;
                end
                s_next.cur_addr = s_reg.cur_addr + {28'h0, grp_words(s_reg.fmt), 2'h0}; // see R21
            end
        end

        // capture sequencer
        case (s_reg.st)
            ST_IDLE: begin
                if (start_cmd) begin
                    s_next.st = ST_SYNC; // see R10
                    s_next.fdone = 2'h0;
                end
            end
            ST_SYNC: begin
                // only the start of an even field opens capture; see R11 R13 R14 R15
                if (vid_field_start && !vid_odd) begin
                    s_next.st = ST_RUN;
                end
            end
            ST_RUN: begin
                if (vid_field_start) begin
                    s_next.fcnt = s_reg.fcnt + 4'h1;
                    s_next.fdone = s_reg.fdone + 2'h1;
                    if (s_reg.one && s_reg.fdone == 2'h1) begin
                        s_next.st = ST_LOCK; // even and odd taken; see R9 R12
                    end
                end
            end
            default: begin
                // locked after a single shot; start is ignored; see R20
                s_next.st = ST_LOCK;
            end
        endcase

        // field start: point at the region of the arriving field
        s_next.cap = s_next.st == ST_RUN;
        if (vid_field_start && s_next.st == ST_RUN) begin
            s_next.lcnt = 10'h000;
            s_next.line_on = 1'b0;
            s_next.gidx = 3'h0;
            if (!vid_odd) begin
                s_next.line_base = s_reg.base_e;
            end else if (s_reg.ilv) begin
                s_next.line_base = s_reg.base_e + lb; // odd lines fall between; see R5 R8
            end else begin
                s_next.line_base = s_reg.base_o; // separate regions alternate; see R6 R7
            end
        end
        if (s_next.st != ST_RUN) begin
            s_next.line_on = 1'b0;
        end

        // halt aborts at once; words already handed over still complete
        if (halt_cmd) begin
            s_next.st = ST_IDLE; // see R12 R20
            s_next.cap = 1'b0;
            s_next.line_on = 1'b0;
            s_next.ocnt = 2'h0;
        end
    end

    // state register
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            s_reg <= '0;
            s_reg.st <= ST_IDLE;
            s_reg.fmt <= `VFCW_FMT_RST;
            s_reg.lpix <= `VFCW_LPIX_RST;
            s_reg.flines <= `VFCW_FLINES_RST;
            s_reg.wait_hi <= 1'b1;
        end else begin
            s_reg <= s_next;
        end
    end

    // outputs straight from the state register
    assign av_readdata = s_reg.rdata;
    assign av_waitrequest = s_reg.wait_hi;
    assign mem_address = s_reg.maddr;
    assign mem_writedata = s_reg.mdata;
    assign mem_write = s_reg.mwr;

    // checks
    default clocking cb_main @(posedge clk); endclocking
    default disable iff (!arst_n);

    sequence s_even_start;
        vid_field_start && !vid_odd;
    endsequence

    sequence s_word_taken;
        mem_write && !mem_waitrequest && s_reg.ocnt != 2'h0 && !halt_cmd;
    endsequence

    chk_start_needs_cmd: assert property ( // see R10
        s_reg.st == ST_IDLE && !start_cmd |=> s_reg.st == ST_IDLE)
        else $error("capture left idle without a start command");

    chk_sync_even_open: assert property ( // see R13
        s_reg.st == ST_SYNC && !halt_cmd ##0 s_even_start |=> s_reg.st == ST_RUN && s_reg.cap)
        else $error("even field start did not open capture");

    chk_sync_no_mid: assert property ( // see R11
        s_reg.st == ST_SYNC && !(vid_field_start && !vid_odd) |=> s_reg.st != ST_RUN)
        else $error("capture opened without an even field start");

    chk_one_shot_end: assert property ( // see R9
        s_reg.st == ST_RUN && s_reg.one && s_reg.fdone == 2'h1 && vid_field_start && !halt_cmd
        |=> s_reg.st == ST_LOCK && !s_reg.cap ##1 !s_reg.line_on)
        else $error("single shot did not stop after two fields");

    chk_lock_hold: assert property ( // see R20
        s_reg.st == ST_LOCK && !halt_cmd |=> s_reg.st == ST_LOCK)
        else $error("locked state left without halt");

    chk_cont_run: assert property ( // see R6
        s_reg.st == ST_RUN && !s_reg.one && !halt_cmd |=> s_reg.st == ST_RUN)
        else $error("continuous capture stopped by itself");

    chk_halt_idle: assert property ( // see R12
        halt_cmd |=> s_reg.st == ST_IDLE && !s_reg.cap && s_reg.ocnt == 2'h0)
        else $error("halt did not stop capture");

    chk_ilv_odd_base: assert property ( // see R5
        s_reg.st == ST_RUN && vid_field_start && vid_odd && s_reg.ilv && !halt_cmd
        |=> s_reg.line_base == $past(s_reg.base_e) + $past(lb))
        else $error("interleaved odd field base wrong");

    chk_sep_odd_base: assert property ( // see R7
        s_reg.st == ST_RUN && vid_field_start && vid_odd && !s_reg.ilv && !halt_cmd
        |=> s_reg.line_base == $past(s_reg.base_o))
        else $error("separate odd field base wrong");

    chk_y8_byte: assert property ( // see R1
        pix_take && s_reg.fmt == `VFCW_FMT_Y8
        |=> s_reg.grp[8 * $past(s_reg.gidx[1:0]) +: 8] == $past(vid_y))
        else $error("grey byte not placed at its pixel position");

    chk_rgb32_pad: assert property ( // see R17
        mem_write && s_reg.fmt == `VFCW_FMT_RGB32 |-> mem_writedata[31:24] == 8'h00)
        else $error("true colour top byte not zero");

    chk_rgb15_msb: assert property ( // see R19
        mem_write && s_reg.fmt == `VFCW_FMT_RGB15 |-> !mem_writedata[15] && !mem_writedata[31])
        else $error("15-bit colour top bit not zero");

    chk_addr_step: assert property ( // see R21
        s_word_taken |=> mem_write && mem_address == $past(mem_address) + 32'h4)
        else $error("group words not at consecutive addresses");

endmodule // vfcw_top
`default_nettype wire
